// ===== hdl/ssrl_core.sv
// Working registers, shadow control, stack pointer, limit and status.
`timescale 1ns/1ps
module ssrl_core
    import ssrl_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         regWrEn,
    input  wire logic [3:0]   regWrIdx,
    input  wire logic [15:0]  regWrData,
    input  wire logic [1:0]   regWrByteEn,
    input  wire logic [3:0]   rdIdx,
    output logic      [15:0]  rdData,
    input  wire logic         ptrUse,
    input  wire logic [3:0]   ptrIdx,
    input  wire logic         shadowSave,
    input  wire logic         shadowRestore,
    input  wire logic         flagUpd,
    input  wire logic [4:0]   flagVal,
    input  wire logic         srWrEn,
    input  wire logic [1:0]   srWrByteEn,
    input  wire logic [15:0]  srWrData,
    input  wire logic         repeatActive,
    input  wire logic         nestDisable,
    input  wire logic         limWrEn,
    input  wire logic [1:0]   limWrByteEn,
    input  wire logic [15:0]  limWrData,
    input  wire ssrl_op_type  stackOp,
    input  wire logic [15:0]  pushData,
    input  wire logic [22:0]  progCounter,
    output logic      [15:0]  stackPtr,
    output logic      [15:0]  stackLimit,
    output logic      [15:0]  cpuStatus,
    output logic      [15:0]  stackAddr,
    output logic      [15:0]  stackWrData,
    output logic              stackWrEn,
    output logic              stackRdEn,
    output logic              stackBusy,
    output logic              stackErrTrap,
    output logic              resetReq,
    output logic              checkEnabled
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [15:0]    regs_r [0:NUM_WREG-1];
    logic [15:0]    uninit_r;
    logic [15:0]    stackPtr_r;
    logic [15:0]    stackLimit_r;
    logic [15:0]    status_r;
    logic [15:0]    statusNxt;
    logic           checkEn_r;
    logic [15:0]    rdData_r;
    logic           resetReq_r;
    ssrl_state_type state_r;
    ssrl_state_type stateNxt;
    logic           popMode_r;
    logic [15:0]    secondWord_r;
    logic [15:0]    stackAddr_r;
    logic [15:0]    stackWrData_r;
    logic           stackWrEn_r;
    logic           stackRdEn_r;
    logic           stackErrTrap_r;
    logic           accActive;
    logic           accWrite;
    logic [15:0]    accEa;
    logic [15:0]    accData;
    logic           spUpdate;
    logic [15:0]    spStack;
    logic [16:0]    limitWide;
    logic           overTrap;
    logic           wrapTrap;
    logic           underTrap;
    logic [15:0]    srMask;
    logic [15:0]    spWrMerged;
    logic [15:0]    limWrMerged;
    logic           stackBusy_r;

    ssrl_if shIf ();

    function automatic logic [15:0] mergeBytes(
        input logic [15:0] oldVal,
        input logic [15:0] newVal,
        input logic [1:0]  be
    );
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        return (oldVal & ~m) | (newVal & m);
    endfunction : mergeBytes

    // ****************************************************************
    // Shadow store
    // ****************************************************************
    // The shadow words are reached only through this private carrier.
    assign shIf.save    = shadowSave;
    assign shIf.wordsIn = {regs_r[3], regs_r[2], regs_r[1], regs_r[0]};
    assign shIf.flagsIn = {status_r[SR_DC], status_r[SR_N],
                           status_r[SR_OV], status_r[SR_Z],
                           status_r[SR_C]};

    ssrl_shadow u_shadow (
        .core_clk (core_clk),
        .rst      (rst),
        .sh       (shIf.shadow)
    );

    // ****************************************************************
    // Working registers and initialization tracking
    // ****************************************************************
    // A restore is applied after an ordinary write and so wins.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_WREG; i++) begin
                regs_r[i] <= REG_RESET;
            end
        end else begin
            if (regWrEn && regWrIdx != SP_IDX) begin
                regs_r[regWrIdx] <= mergeBytes(regs_r[regWrIdx],
                                               regWrData, regWrByteEn);
            end
            if (shadowRestore) begin
                for (int i = 0; i < NUM_SHADOW; i++) begin
                    regs_r[i] <= shIf.wordsOut[i*16 +: 16];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            uninit_r <= UNINIT_ALL;
        end else begin
            if (regWrEn && regWrIdx != SP_IDX &&
                regWrByteEn == BYTE_WORD) begin
                uninit_r[regWrIdx] <= 1'b0;
            end
            if (shadowRestore) begin
                uninit_r[NUM_SHADOW-1:0] <= '0;
            end
        end
    end

    // Each pointer use of an unwritten register gives one pulse.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            resetReq_r <= 1'b0;
        end else begin
            resetReq_r <= ptrUse && ptrIdx != SP_IDX &&
                          uninit_r[ptrIdx];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdData_r <= REG_RESET;
        end else if (rdIdx == SP_IDX) begin
            rdData_r <= stackPtr_r;
        end else begin
            rdData_r <= regs_r[rdIdx];
        end
    end

    // ****************************************************************
    // Stack sequencer
    // ****************************************************************
    always_comb begin
        accActive = 1'b0;
        accWrite  = 1'b0;
        accEa     = stackPtr_r;
        accData   = pushData;
        spUpdate  = 1'b0;
        spStack   = stackPtr_r;
        stateNxt  = state_r;
        unique case (state_r)
            ST_IDLE: begin
                unique case (stackOp)
                    OP_NONE: begin
                    end
                    OP_PUSH: begin
                        accActive = 1'b1;
                        accWrite  = 1'b1;
                        spUpdate  = 1'b1;
                        spStack   = stackPtr_r + STACK_STEP;
                    end
                    OP_CALL, OP_EXC: begin
                        accActive = 1'b1;
                        accWrite  = 1'b1;
                        accData   = progCounter[15:0];
                        spUpdate  = 1'b1;
                        spStack   = stackPtr_r + STACK_STEP;
                        stateNxt  = ST_SECOND;
                    end
                    OP_POP, OP_RET: begin
                        accActive = 1'b1;
                        accEa     = stackPtr_r - STACK_STEP;
                        spUpdate  = 1'b1;
                        spStack   = stackPtr_r - STACK_STEP;
                        if (stackOp == OP_RET) begin
                            stateNxt = ST_SECOND;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            ST_SECOND: begin
                accActive = 1'b1;
                spUpdate  = 1'b1;
                stateNxt  = ST_IDLE;
                if (popMode_r) begin
                    accEa   = stackPtr_r - STACK_STEP;
                    spStack = stackPtr_r - STACK_STEP;
                end else begin
                    accWrite = 1'b1;
                    accData  = secondWord_r;
                    spStack  = stackPtr_r + STACK_STEP;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r     <= ST_IDLE;
            stackBusy_r <= 1'b0;
        end else begin
            state_r     <= stateNxt;
            stackBusy_r <= (stateNxt == ST_SECOND);
        end
    end

    // Upper stacked word is built when the sequence starts.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            popMode_r    <= 1'b0;
            secondWord_r <= REG_RESET;
        end else if (state_r == ST_IDLE) begin
            popMode_r <= (stackOp == OP_RET);
            if (stackOp == OP_EXC) begin
                secondWord_r <= {status_r[7:0], 1'b0,
                                 progCounter[PC_HI:PC_MID]};
            end else begin
                secondWord_r <= {CALL_FILL, 1'b0,
                                 progCounter[PC_HI:PC_MID]};
            end
        end
    end

    assign spWrMerged = mergeBytes(stackPtr_r, regWrData, regWrByteEn);

    // Automatic updates win over a software write in the same cycle.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stackPtr_r <= SP_RESET;
        end else if (spUpdate) begin
            stackPtr_r <= {spStack[15:1], 1'b0};
        end else if (regWrEn && regWrIdx == SP_IDX) begin
            stackPtr_r <= {spWrMerged[15:1], 1'b0};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stackAddr_r   <= REG_RESET;
            stackWrData_r <= REG_RESET;
            stackWrEn_r   <= 1'b0;
            stackRdEn_r   <= 1'b0;
        end else begin
            stackAddr_r   <= accEa;
            stackWrData_r <= accData;
            stackWrEn_r   <= accActive && accWrite;
            stackRdEn_r   <= accActive && !accWrite;
        end
    end

    // ****************************************************************
    // Stack limit and error detection
    // ****************************************************************
    assign limWrMerged = mergeBytes(stackLimit_r, limWrData, limWrByteEn);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stackLimit_r <= LIMIT_RESET;
        end else if (limWrEn) begin
            stackLimit_r <= {limWrMerged[15:1], 1'b0};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            checkEn_r <= 1'b0;
        end else if (limWrEn && limWrByteEn == BYTE_WORD) begin
            checkEn_r <= 1'b1;
        end
    end

    assign limitWide = {1'b0, stackLimit_r} + {1'b0, LIMIT_MARGIN};
    assign overTrap  = checkEn_r &&
                       ({1'b0, accEa} > limitWide);
    assign wrapTrap  = checkEn_r &&
                       ((accWrite && stackPtr_r == SP_TOP_WORD) ||
                        (!accWrite && stackPtr_r < STACK_STEP));
    assign underTrap = accEa < STACK_FLOOR;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stackErrTrap_r <= 1'b0;
        end else begin
            stackErrTrap_r <= accActive &&
                (overTrap || wrapTrap || underTrap);
        end
    end

    // ****************************************************************
    // Status register
    // ****************************************************************
    always_comb begin
        statusNxt = status_r;
        srMask    = SR_WR_MASK & {{8{srWrByteEn[1]}}, {8{srWrByteEn[0]}}};
        if (nestDisable) begin
            srMask = srMask & ~SR_IPL_MASK;
        end
        if (flagUpd) begin
            {statusNxt[SR_DC], statusNxt[SR_N], statusNxt[SR_OV],
             statusNxt[SR_Z], statusNxt[SR_C]} = flagVal;
        end
        if (srWrEn) begin
            statusNxt = (statusNxt & ~srMask) | (srWrData & srMask);
        end
        if (shadowRestore) begin
            {statusNxt[SR_DC], statusNxt[SR_N], statusNxt[SR_OV],
             statusNxt[SR_Z], statusNxt[SR_C]} = shIf.flagsOut;
        end
        statusNxt         = statusNxt & (SR_WR_MASK | SR_IPL_MASK);
        statusNxt[SR_RA]  = repeatActive;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_r <= SR_RESET;
        end else begin
            status_r <= statusNxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rdData       = rdData_r;
    assign stackPtr     = stackPtr_r;
    assign stackLimit   = stackLimit_r;
    assign cpuStatus    = status_r;
    assign stackAddr    = stackAddr_r;
    assign stackWrData  = stackWrData_r;
    assign stackWrEn    = stackWrEn_r;
    assign stackRdEn    = stackRdEn_r;
    assign stackBusy    = stackBusy_r;
    assign stackErrTrap = stackErrTrap_r;
    assign resetReq     = resetReq_r;
    assign checkEnabled = checkEn_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_saveCopies;
        @(posedge core_clk) disable iff (rst)
        shadowSave |=> (shIf.wordsOut == $past(shIf.wordsIn)) &&
                       (shIf.flagsOut == $past(shIf.flagsIn));
    endproperty
    a_saveCopies: assert property (p_saveCopies)
        else $error("shadow save did not capture registers and flags");

    property p_restoreBack;
        @(posedge core_clk) disable iff (rst)
        shadowRestore |=> (regs_r[3] == $past(shIf.wordsOut[63:48])) &&
                          (status_r[SR_DC] == $past(shIf.flagsOut[4])) &&
                          (uninit_r[3:0] == 4'h0);
    endproperty
    a_restoreBack: assert property (p_restoreBack)
        else $error("shadow restore did not reach registers or flags");

    property p_spAligned;
        @(posedge core_clk) disable iff (rst)
        stackPtr_r[0] == 1'b0 && stackLimit_r[0] == 1'b0;
    endproperty
    a_spAligned: assert property (p_spAligned)
        else $error("stack pointer or limit lost word alignment");

    property p_resetValues;
        @(posedge core_clk)
        rst |=> stackPtr_r == SP_RESET && uninit_r == UNINIT_ALL &&
                       stackLimit_r == LIMIT_RESET && !checkEn_r;
    endproperty
    a_resetValues: assert property (p_resetValues)
        else $error("reset values wrong after reset");

    property p_pushStep;
        @(posedge core_clk) disable iff (rst)
        (state_r == ST_IDLE && stackOp == OP_PUSH) |=>
            stackPtr_r == $past(stackPtr_r) + STACK_STEP && stackWrEn_r &&
            stackAddr_r == $past(stackPtr_r);
    endproperty
    a_pushStep: assert property (p_pushStep)
        else $error("push did not write at pointer and step by two");

    property p_callOrder;
        @(posedge core_clk) disable iff (rst)
        (state_r == ST_IDLE && stackOp == OP_CALL) |=>
            stackWrData_r == $past(progCounter[15:0]) ##1
            stackWrEn_r && stackWrData_r[15:7] == 9'h000 &&
            stackWrData_r[6:0] == $past(progCounter[PC_HI:PC_MID], 2);
    endproperty
    a_callOrder: assert property (p_callOrder)
        else $error("call stacked program counter in wrong order");

    property p_checkSticky;
        @(posedge core_clk) disable iff (rst)
        checkEn_r |=> checkEn_r;
    endproperty
    a_checkSticky: assert property (p_checkSticky)
        else $error("overflow check disabled without reset");

    property p_underTrap;
        @(posedge core_clk) disable iff (rst)
        (accActive && accEa < STACK_FLOOR) |=> stackErrTrap_r;
    endproperty
    a_underTrap: assert property (p_underTrap)
        else $error("stack access below floor gave no trap");

    property p_overTrap;
        @(posedge core_clk) disable iff (rst)
        (accActive && checkEn_r && {1'b0, accEa} > limitWide) |=>
            stackErrTrap_r;
    endproperty
    a_overTrap: assert property (p_overTrap)
        else $error("stack access past limit gave no trap");

    property p_repeatReadOnly;
        @(posedge core_clk) disable iff (rst)
        srWrEn |=> status_r[SR_RA] == $past(repeatActive) &&
            (!$past(nestDisable) || status_r[7:5] == $past(status_r[7:5]));
    endproperty
    a_repeatReadOnly: assert property (p_repeatReadOnly)
        else $error("status write changed a protected field");

    property p_uninitReset;
        @(posedge core_clk) disable iff (rst)
        (ptrUse && ptrIdx != SP_IDX && uninit_r[ptrIdx]) |=> resetReq_r;
    endproperty
    a_uninitReset: assert property (p_uninitReset)
        else $error("unwritten pointer use gave no reset request");

endmodule : ssrl_core

// ===== hdl/ssrl_pkg.sv
// Constants, types and behaviour summary of the stack and shadow logic.
// Behaviour
// - Shadow save copies W0-W3 and five flags.
// - Shadow restore writes copies back to registers.
// - Shadow holds one set; save overwrites.
// - Shadow copies reachable only by save/restore.
// - Reset clears W0-W14, marks them uninitialized.
// - Uninitialized register used as pointer resets device.
// - Only word writes and shadow restore (W0-W3) clear the uninitialized mark.
// - Stack pointer bit zero always reads zero.
// - Stack pointer resets to 0x0800, auto updated.
// - Stack grows up: post-increment push, pre-decrement pop.
// - Program counter low word first, upper bits next.
// - Exception entry stacks status low byte too.
// - Stack limit 16 bits, resets zero, bit0 zero.
// - First word write to limit enables overflow check.
// - Trap when address exceeds limit by more than two.
// - Overflow check covers every stack pointer address.
// - Checked stack address wrapping past top traps.
// - Stack address below 0x0800 always traps.
// - Status layout: flags, repeat, priority, digit carry.
// - Repeat flag read only; priority locked by nesting.
package ssrl_pkg;

    localparam int         NUM_WREG     = 15;
    localparam int         NUM_SHADOW   = 4;
    localparam int         FLAG_W       = 5;
    localparam logic [3:0] SP_IDX       = 4'hf;
    localparam logic [1:0] BYTE_WORD    = 2'h3;

    localparam logic [15:0] SP_RESET     = 16'h0800;
    localparam logic [15:0] STACK_FLOOR  = 16'h0800;
    localparam logic [15:0] LIMIT_RESET  = 16'h0000;
    localparam logic [15:0] REG_RESET    = 16'h0000;
    localparam logic [15:0] SR_RESET     = 16'h0000;
    localparam logic [15:0] UNINIT_ALL   = 16'h7fff;
    localparam logic [15:0] STACK_STEP   = 16'h0002;
    localparam logic [15:0] LIMIT_MARGIN = 16'h0002;
    localparam logic [15:0] SP_TOP_WORD  = 16'hfffe;
    localparam logic [15:0] SR_WR_MASK   = 16'h01ef;
    localparam logic [15:0] SR_IPL_MASK  = 16'h00e0;
    localparam logic [7:0]  CALL_FILL    = 8'h00;

    localparam int SR_C  = 0;
    localparam int SR_Z  = 1;
    localparam int SR_OV = 2;
    localparam int SR_N  = 3;
    localparam int SR_RA = 4;
    localparam int SR_DC = 8;
    localparam int PC_HI = 22;
    localparam int PC_MID = 16;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_PUSH = 3'h1,
        OP_POP  = 3'h2,
        OP_CALL = 3'h3,
        OP_EXC  = 3'h4,
        OP_RET  = 3'h5
    } ssrl_op_type;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_SECOND = 2'h1
    } ssrl_state_type;

endpackage : ssrl_pkg

// ===== hdl/ssrl_if.sv
// Carrier between the core logic and its shadow store.
`timescale 1ns/1ps
interface ssrl_if;
    logic        save;
    logic [63:0] wordsIn;
    logic [4:0]  flagsIn;
    logic [63:0] wordsOut;
    logic [4:0]  flagsOut;

    modport core   (output save, wordsIn, flagsIn,
                    input  wordsOut, flagsOut);
    modport shadow (input  save, wordsIn, flagsIn,
                    output wordsOut, flagsOut);
endinterface : ssrl_if

// ===== hdl/ssrl_shadow.sv
// One-level shadow store for four working registers and five flags.
`timescale 1ns/1ps
module ssrl_shadow
    import ssrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    ssrl_if.shadow   sh
);

    logic [63:0] words_r;
    logic [4:0]  flags_r;

    // Each save replaces the single held set.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            words_r <= {NUM_SHADOW{REG_RESET}};
            flags_r <= SR_RESET[FLAG_W-1:0];
        end else if (sh.save) begin
            words_r <= sh.wordsIn;
            flags_r <= sh.flagsIn;
        end
    end

    assign sh.wordsOut = words_r;
    assign sh.flagsOut = flags_r;

endmodule : ssrl_shadow

// ===== tb/ssrl_stack_mem.sv
// Behavioural stack memory standing at the far side of the stack port.
`timescale 1ns/1ps
module ssrl_stack_mem (
    input  wire logic        core_clk,
    input  wire logic        wrEn,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wrData,
    input  wire logic [15:0] rdAddr,
    output logic      [15:0] rdWord
);
    logic [15:0] mem [0:32767];

    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            mem[addr[15:1]] <= wrData;
        end
    end
    assign rdWord = mem[rdAddr[15:1]];
endmodule : ssrl_stack_mem

// ===== tb/ssrl_core_test.sv
// Self-checking bench for the stack and shadow register logic.
`timescale 1ns/1ps
module ssrl_core_test;
    import ssrl_pkg::*;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic        core_clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, ptrUse = 1'b0;
    logic        shadowSave = 1'b0, shadowRestore = 1'b0, flagUpd = 1'b0;
    logic        srWrEn = 1'b0, repeatActive = 1'b0, nestDisable = 1'b0;
    logic        limWrEn = 1'b0;
    logic [3:0]  regWrIdx = 4'h0, rdIdx = 4'h0, ptrIdx = 4'h0;
    logic [1:0]  regWrByteEn = 2'h3, srWrByteEn = 2'h3, limWrByteEn = 2'h3;
    logic [4:0]  flagVal = 5'h00;
    logic [15:0] regWrData = 16'h0, srWrData = 16'h0, limWrData = 16'h0;
    logic [15:0] pushData = 16'h0, memAddr = 16'h0, d1, d2, memWord;
    logic [22:0] progCounter = 23'h0;
    ssrl_op_type stackOp = OP_NONE;
    logic [15:0] rdData, stackPtr, stackLimit, cpuStatus, stackAddr;
    logic [15:0] stackWrData;
    logic        stackWrEn, stackRdEn, stackBusy, stackErrTrap, resetReq;
    logic        checkEnabled;
    logic [31:0] expQ [$];
    logic [31:0] note;
    logic [7:0]  fill [2] = '{8'h00, 8'hfa};
    int          miscompares = 0, num_checks = 0, traps = 0, resets = 0;
    int          cycles = 0, seed = 68500;

    ssrl_core u_ssrl_core (.core_clk, .rst, .regWrEn, .regWrIdx, .regWrData,
        .regWrByteEn, .rdIdx, .rdData, .ptrUse, .ptrIdx, .shadowSave,
        .shadowRestore, .flagUpd, .flagVal, .srWrEn, .srWrByteEn, .srWrData,
        .repeatActive, .nestDisable, .limWrEn, .limWrByteEn, .limWrData,
        .stackOp, .pushData, .progCounter, .stackPtr, .stackLimit, .cpuStatus,
        .stackAddr, .stackWrData, .stackWrEn, .stackRdEn, .stackBusy,
        .stackErrTrap, .resetReq, .checkEnabled);
    ssrl_stack_mem u_ssrl_stack_mem (.core_clk, .wrEn(stackWrEn),
        .addr(stackAddr), .wrData(stackWrData), .rdAddr(memAddr),
        .rdWord(memWord));

    initial forever #12.5 core_clk = ~core_clk;

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [3:0] i, input logic [15:0] d,
                      input logic [1:0] b);
        {regWrEn, regWrIdx, regWrData, regWrByteEn} = {1'b1, i, d, b};
        cyc(1);
        regWrEn = 1'b0;
        cyc(1);
    endtask : wr
    task automatic rd(input logic [3:0] i, input logic [15:0] e);
        rdIdx = i;
        cyc(1);
        chk(rdData, e);
    endtask : rd
    task automatic op(input ssrl_op_type o, input int n);
        stackOp = o;
        cyc(1);
        stackOp = OP_NONE;
        cyc(n);
    endtask : op
    task automatic ptr(input logic [3:0] i);
        {ptrUse, ptrIdx} = {1'b1, i};
        cyc(1);
        ptrUse = 1'b0;
        cyc(2);
    endtask : ptr

    // The monitor compares every stack access with the oldest note.
    always @(posedge core_clk) begin
        cycles++;
        if (stackErrTrap === 1'b1) traps++;
        if (resetReq === 1'b1) resets++;
        if (stackWrEn === 1'b1 || stackRdEn === 1'b1) begin
            note = (expQ.size() > 0) ? expQ.pop_front() : 32'hx;
            chk(stackAddr, note[31:16]);
            if (stackWrEn === 1'b1) begin
                chk(stackWrData, note[15:0]);
            end
        end
        if (cycles > 3000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        cyc(10);
        rst = 1'b0;
        chk(stackPtr, 16'h0800);
        chk(stackLimit, 16'h0000);
        chk({15'h0, checkEnabled}, 16'h0);
        rd(4'h5, 16'h0000);
        wr(4'h2, 16'h0900, 2'h1);
        ptr(4'h2);
        chk(resets[15:0], 16'h1);
        wr(4'h2, 16'h0900, 2'h3);
        ptr(4'h2);
        chk(resets[15:0], 16'h1);
        $display("test pointer marks done");
        // Two saves come before a single restore here; the second save overwrites the first.
        d1 = $random(seed);
        d2 = $random(seed);
        repeatActive = 1'b1;
        wr(4'h0, d1, 2'h3);
        {shadowSave, srWrEn, srWrData} = {1'b1, 1'b1, 16'hffff};
        cyc(1);
        {shadowSave, srWrEn} = 2'b00;
        cyc(1);
        chk(cpuStatus, 16'h01ff);
        wr(4'h0, d2, 2'h3);
        shadowSave = 1'b1;
        cyc(1);
        {shadowSave, nestDisable, srWrEn, srWrData} = {3'b011, 16'h0};
        cyc(1);
        srWrEn = 1'b0;
        cyc(1);
        chk(cpuStatus, 16'h00f0);
        wr(4'h0, ~d2, 2'h3);
        shadowRestore = 1'b1;
        cyc(1);
        shadowRestore = 1'b0;
        rd(4'h0, d2);
        chk(cpuStatus, 16'h01ff);
        {flagUpd, flagVal} = {1'b1, 5'h0a};
        cyc(1);
        flagUpd = 1'b0;
        chk(cpuStatus, 16'h00fa);
        $display("test shadow done");
        pushData = $random(seed);
        expQ.push_back({16'h0800, pushData});
        op(OP_PUSH, 1);
        chk(stackPtr, 16'h0802);
        expQ.push_back({16'h0800, 16'h0000});
        op(OP_POP, 1);
        memAddr = 16'h0800;
        chk(stackPtr, 16'h0800);
        chk(memWord, pushData);
        for (int k = 0; k < 2; k++) begin
            progCounter = $random(seed);
            memAddr = 16'h0800 + 16'(4 * k);
            expQ.push_back({memAddr, progCounter[15:0]});
            expQ.push_back({memAddr + 16'h2, fill[k], 1'b0,
                            progCounter[22:16]});
            op(k == 0 ? OP_CALL : OP_EXC, 0);
            chk({15'h0, stackBusy}, 16'h1);
            cyc(2);
        end
        chk(stackPtr, 16'h0808);
        chk({15'h0, stackBusy}, 16'h0);
        expQ.push_back({16'h0806, 16'h0000});
        expQ.push_back({16'h0804, 16'h0000});
        op(OP_RET, 2);
        chk(stackPtr, 16'h0804);
        $display("test stack order done");
        wr(4'hf, 16'h0701, 2'h3);
        chk(stackPtr, 16'h0700);
        expQ.push_back({16'h0700, pushData});
        op(OP_PUSH, 2);
        chk(traps[15:0], 16'h1);
        wr(4'hf, 16'h0804, 2'h3);
        {limWrEn, limWrData, limWrByteEn} = {1'b1, 16'h0807, 2'h1};
        cyc(1);
        chk({15'h0, checkEnabled}, 16'h0);
        limWrByteEn = 2'h3;
        cyc(1);
        limWrEn = 1'b0;
        cyc(1);
        chk(stackLimit, 16'h0806);
        chk({15'h0, checkEnabled}, 16'h1);
        // Only pushes follow the limit write.
        for (int k = 0; k < 4; k++) begin
            expQ.push_back({16'h0804 + 16'(2 * k), pushData});
        end
        repeat (3) op(OP_PUSH, 1);
        chk(traps[15:0], 16'h1);
        op(OP_PUSH, 2);
        chk(traps[15:0], 16'h2);
        chk(16'(expQ.size()), 16'h0);
        $display("test limits done");
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        chk(stackPtr, 16'h0800);
        chk(stackLimit, 16'h0000);
        chk({15'h0, checkEnabled}, 16'h0);
        rd(4'h2, 16'h0000);
        ptr(4'h2);
        chk(resets[15:0], 16'h2);
        $display("test reset done");
        wrap_up();
    end
endmodule : ssrl_core_test
